// ---- rtl/cec_pkg.sv ----
// package of offsets, fields and reset values for the comparator event control
package cec_pkg;
  localparam int CEC_NUM = 5;
  localparam logic [3:0] CEC_IDX_STATUS = 4'h0;
  localparam logic [3:0] CEC_IDX_CTRL1 = 4'h1;
  localparam logic [3:0] CEC_IDX_IRQ = 4'h6;
  localparam int CEC_OPAMP_LESS = 3;
  localparam int B_IDLE_STOP = 15;
  localparam int B_EVT_LO = 8;
  localparam int B_ON = 15;
  localparam int B_OE = 14;
  localparam int B_INV = 13;
  localparam int B_OPA = 10;
  localparam int B_EVT = 9;
  localparam int B_RES = 8;
  localparam int B_EDGE = 6;
  localparam int B_REF = 4;
  localparam int B_NEG = 0;
  localparam int B_IRQ_FLAG = 0;
  localparam int B_IRQ_EN = 1;
  localparam logic [15:0] CEC_CTRL_WMASK = 16'hE4D3;
  localparam logic [15:0] CEC_CTRL_WMASK4 = 16'hE0D3;
  localparam logic [15:0] CEC_RESET = 16'h0000;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
endpackage

// ---- rtl/cec_top.sv ----
// comparator control, input routing, edge events and status behind a wishbone slave
// Function
// - idle stop halts all comparators in idle
// - status bits 12-8 mirror event flags
// - status bits 4-0 mirror adjusted outputs
// - op amp enable leaves comparator working
// - event flag set blocks further events
// - edge code 11 fires on any change
// - edge code 10 fires on falling output
// - edge code 01 fires on rising output
// - edge code 00 fires nothing
// - reference select picks internal reference or pin
// - channel field picks negative pin one-four
// - absent inputs are tied to ground, except an absent minus pin with reference selected: plus pin vs reference
// - all events set one combined flag
// - comparator four lacks op amp bits
`timescale 1ns/10ps
module cec_top
  import cec_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [3:0] wb_adr_i, // word index
  input wire logic [1:0] wb_sel_i, // byte lanes
  input wire logic [15:0] wb_dat_i, // write data
  output logic [15:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic idle_mode, // device is in idle
  input wire logic [4:0] pos_gt_ref, // analog: plus pin above internal reference, one per channel
  input wire logic [19:0] pos_pin_gt_neg, // analog: pin one above negative pin n, 4 per channel
  input wire logic [19:0] ref_gt_neg, // analog: internal reference above negative pin n
  input wire logic [19:0] neg_present, // negative pin exists on this package
  input wire logic [4:0] pos_present, // plus pin exists on this package
  output logic [4:0] comparator_output_pin, // result on dedicated pins
  output logic [4:0] comparator_output_pin_oe, // pin drive enable
  output logic [4:0] opamp_on, // op amp powered
  output logic [4:0] comparator_active, // comparator running
  output logic combined_irq // combined flag and enable
);
  logic [15:0] ctrl [CEC_NUM];
  logic idle_stop;
  logic combined_irq_flag;
  logic combined_irq_enable;
  logic [4:0] res_prev;
  logic [4:0] res_sync;
  logic [4:0] event_flag;
  logic [4:0] comparator_result;
  logic wb_req;
  logic wr_stb;
  logic [15:0] rd_word;
  logic [4:0] run;
  logic [4:0] raw_cmp;
  logic [4:0] hit;
  logic [4:0] sw_clr;
  logic [4:0] ctrl_sel;
  logic [2:0] ctrl_idx;
  logic [15:0] ctrl_rd;
  logic [15:0] next_ctrl [CEC_NUM];
  logic [4:0] next_flag;

  // request taken while ack is low; a write commits on the edge that sees its ack
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // byte-lane write merge under a writable mask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                       input logic [1:0] sel, input logic [15:0] m);
    logic [15:0] lanes;
    lanes = {{8{sel[1]}}, {8{sel[0]}}} & m;
    merge = (old & ~lanes) | (d & lanes);
  endfunction

  // per-channel routing, compare and edge detection
  genvar g;
  generate
    for (g = 0; g < CEC_NUM; g++)
    begin : gch
      logic [1:0] nsel;
      logic neg_ok;
      logic pos_ok;
      logic gt;
      logic edge_any;
      logic edge_rise;
      logic edge_fall;
      logic [1:0] mode;
      assign nsel = ctrl[g][B_NEG+1:B_NEG];
      assign neg_ok = neg_present[g*4+nsel];
      assign pos_ok = ctrl[g][B_REF] || pos_present[g];
      // grounded input reads as zero volts: plus above ground if plus present and minus absent, but plus pin above reference if the reference is selected
      assign gt = !pos_ok ? 1'b0 :
                  !neg_ok ? (ctrl[g][B_REF] ? pos_gt_ref[g] : 1'b1) :
                  ctrl[g][B_REF] ? ref_gt_neg[g*4+nsel] : pos_pin_gt_neg[g*4+nsel];
      assign raw_cmp[g] = gt ^ ctrl[g][B_INV];
      assign run[g] = ctrl[g][B_ON] && !(idle_stop && idle_mode);
      assign mode = ctrl[g][B_EDGE+1:B_EDGE];
      assign edge_any = res_sync[g] != res_prev[g];
      assign edge_rise = res_sync[g] && !res_prev[g];
      assign edge_fall = !res_sync[g] && res_prev[g];
      assign hit[g] = run[g] && !event_flag[g] &&
                      ((mode == EDGE_ANY && edge_any) ||
                       (mode == EDGE_FALL && edge_fall) ||
                       (mode == EDGE_RISE && edge_rise));
      assign ctrl_sel[g] = wr_stb && wb_adr_i == CEC_IDX_CTRL1 + 4'(g);
      assign sw_clr[g] = ctrl_sel[g] && wb_sel_i[1] && !wb_dat_i[B_EVT];
    end
  endgenerate

  // read mux; a control word gathers its read-only flag and result bits
  assign ctrl_idx = 3'(wb_adr_i - CEC_IDX_CTRL1);
  assign ctrl_rd = ctrl[ctrl_idx] | (16'(event_flag[ctrl_idx]) << B_EVT) |
                   (16'(comparator_result[ctrl_idx]) << B_RES);
  assign rd_word = (wb_adr_i == CEC_IDX_STATUS) ?
                     {idle_stop, 2'h0, event_flag, 3'h0, comparator_result} :
                   (wb_adr_i >= CEC_IDX_CTRL1 && wb_adr_i < CEC_IDX_CTRL1 + 4'(CEC_NUM)) ?
                     ctrl_rd :
                   (wb_adr_i == CEC_IDX_IRQ) ? {14'h0, combined_irq_enable, combined_irq_flag} :
                   16'h0000;

  // bus answer, one cycle after request
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 16'h0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 16'h0000;
    end
  end

  // result sampling, forced to zero when stopped
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_sync <= 5'h00;
      res_prev <= 5'h00;
    end
    else
    begin
      res_sync <= run & raw_cmp;
      res_prev <= res_sync;
    end
  end
  assign comparator_result = res_sync;

  // next control words under each channel's writable mask
  generate
    for (g = 0; g < CEC_NUM; g++)
    begin : greg
      logic [15:0] wm;
      assign wm = (g == CEC_OPAMP_LESS) ? CEC_CTRL_WMASK4 : CEC_CTRL_WMASK;
      assign next_ctrl[g] = ctrl_sel[g] ? merge(ctrl[g], wb_dat_i, wb_sel_i, wm) : ctrl[g];
    end
  endgenerate
  // event flags: a set wins over a software clear in the same cycle
  assign next_flag = hit | (event_flag & ~sw_clr);

  // control registers and event flags, one process so each has a single driver
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < CEC_NUM; i++)
        ctrl[i] <= CEC_RESET;
      event_flag <= 5'h00;
    end
    else
    begin
      for (int i = 0; i < CEC_NUM; i++)
        ctrl[i] <= next_ctrl[i];
      event_flag <= next_flag;
    end
  end

  // shared idle stop and combined interrupt flag
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_stop <= 1'b0;
      combined_irq_flag <= 1'b0;
      combined_irq_enable <= 1'b0;
    end
    else
    begin
      if (wr_stb && wb_adr_i == CEC_IDX_STATUS && wb_sel_i[1])
        idle_stop <= wb_dat_i[B_IDLE_STOP];
      if (wr_stb && wb_adr_i == CEC_IDX_IRQ && wb_sel_i[0])
        combined_irq_enable <= wb_dat_i[B_IRQ_EN];
      if (|hit)
        combined_irq_flag <= 1'b1;
      else if (wr_stb && wb_adr_i == CEC_IDX_IRQ && wb_sel_i[0] && !wb_dat_i[B_IRQ_FLAG])
        combined_irq_flag <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comparator_output_pin <= 5'h00;
      comparator_output_pin_oe <= 5'h00;
      opamp_on <= 5'h00;
      comparator_active <= 5'h00;
      combined_irq <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < CEC_NUM; i++)
      begin
        comparator_output_pin[i] <= ctrl[i][B_OE] & res_sync[i];
        comparator_output_pin_oe[i] <= ctrl[i][B_OE] & run[i];
        opamp_on[i] <= ctrl[i][B_OPA] & run[i];
      end
      comparator_active <= run;
      combined_irq <= combined_irq_flag & combined_irq_enable;
    end
  end

  // a selected edge leaves its event flag and the combined flag set
  a_edge_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
    |hit |=> (|event_flag) && combined_irq_flag)
    else $error("edge did not set flags");
  // a set event flag keeps its channel from firing again
  a_flag_blocks_hit: assert property (@(posedge clock) disable iff (!rst_n)
    (event_flag & hit) == 5'h00)
    else $error("event fired while flag set");
  // a software clear takes the flag down when no edge competes
  a_flag_clears: assert property (@(posedge clock) disable iff (!rst_n)
    sw_clr[0] && !hit[0] |=> !event_flag[0])
    else $error("event flag did not clear");
  // edge code 00 keeps comparator one quiet
  a_edge_off_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl[0][B_EDGE+1:B_EDGE] == EDGE_OFF |-> !hit[0])
    else $error("event with edges off");
  // any change of the adjusted result fires in code 11
  a_any_change_hit: assert property (@(posedge clock) disable iff (!rst_n)
    run[0] && ctrl[0][B_EDGE+1:B_EDGE] == EDGE_ANY && !event_flag[0] && $changed(res_sync[0]) |-> hit[0])
    else $error("any-change edge missed");
  // code 10 fires only on a falling adjusted result
  a_fall_only: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl[0][B_EDGE+1:B_EDGE] == EDGE_FALL && hit[0] |-> $fell(res_sync[0]))
    else $error("fall mode misfired");
  // code 01 fires only on a rising adjusted result
  a_rise_only: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl[0][B_EDGE+1:B_EDGE] == EDGE_RISE && hit[0] |-> $rose(res_sync[0]))
    else $error("rise mode misfired");
  // edges compare against the result of the cycle before
  a_edge_prev: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> res_prev == $past(res_sync))
    else $error("edge history lost");
  // comparator four never offers op amp bits
  a_four_no_opamp: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl[CEC_OPAMP_LESS][12:10] == 3'h0 && !opamp_on[CEC_OPAMP_LESS])
    else $error("channel four op amp bits set");
  // idle stop halts every comparator while idle
  a_idle_halts: assert property (@(posedge clock) disable iff (!rst_n)
    idle_stop && idle_mode |=> comparator_active == 5'h00)
    else $error("comparators ran in idle");
  // without idle stop an enabled comparator keeps running
  a_idle_runs: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl[0][B_ON] && !idle_stop |=> comparator_active[0])
    else $error("comparator stopped without idle stop");
  // a comparator that is off reports a zero result
  a_result_off: assert property (@(posedge clock) disable iff (!rst_n)
    !run[0] |=> !comparator_result[0])
    else $error("result shown while off");
  // the op amp runs only beside a working comparator
  a_opamp_with_cmp: assert property (@(posedge clock) disable iff (!rst_n)
    (opamp_on & ~comparator_active) == 5'h00)
    else $error("op amp on without comparator");
  // a clear output enable keeps the pin undriven
  a_pin_follows: assert property (@(posedge clock) disable iff (!rst_n)
    !ctrl[1][B_OE] |=> !comparator_output_pin_oe[1] && !comparator_output_pin[1])
    else $error("pin driven while off");
  // the reference feeds the plus side when selected
  a_ref_routes: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl[0][B_REF] && neg_present[ctrl[0][B_NEG+1:B_NEG]] |->
      raw_cmp[0] == (ref_gt_neg[ctrl[0][B_NEG+1:B_NEG]] ^ ctrl[0][B_INV]))
    else $error("reference routing wrong");
  // the channel field picks the minus pin against plus pin one
  a_neg_routes: assert property (@(posedge clock) disable iff (!rst_n)
    !ctrl[0][B_REF] && pos_present[0] && neg_present[ctrl[0][B_NEG+1:B_NEG]] |->
      raw_cmp[0] == (pos_pin_gt_neg[ctrl[0][B_NEG+1:B_NEG]] ^ ctrl[0][B_INV]))
    else $error("minus pin routing wrong");
  // an absent minus pin acts as ground
  a_neg_ground: assert property (@(posedge clock) disable iff (!rst_n)
    run[1] && !ctrl[1][B_REF] && pos_present[1] && !neg_present[4 + ctrl[1][B_NEG+1:B_NEG]] |->
      raw_cmp[1] == !ctrl[1][B_INV])
    else $error("absent pin not grounded");
  // status read mirrors event flags and results
  a_status_mirror: assert property (@(posedge clock) disable iff (!rst_n)
    wb_req && wb_adr_i == CEC_IDX_STATUS |=>
      wb_dat_o[12:8] == $past(event_flag) && wb_dat_o[4:0] == $past(res_sync))
    else $error("status mirror wrong");
  // a control read of comparator one carries its flag and result
  a_ctrl_mirror: assert property (@(posedge clock) disable iff (!rst_n)
    wb_req && wb_adr_i == CEC_IDX_CTRL1 |=>
      wb_dat_o[B_EVT] == $past(event_flag[0]) && wb_dat_o[B_RES] == $past(res_sync[0]))
    else $error("control read lost flag or result");
  // the combined request follows flag and enable
  a_irq_follows: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> combined_irq == $past(combined_irq_flag && combined_irq_enable))
    else $error("combined request wrong");
  // a combined flag clear takes effect when no event competes
  a_irq_clear: assert property (@(posedge clock) disable iff (!rst_n)
    wr_stb && wb_adr_i == CEC_IDX_IRQ && wb_sel_i[0] && !wb_dat_i[B_IRQ_FLAG] && !(|hit) |=>
      !combined_irq_flag)
    else $error("combined flag did not clear");
endmodule

// ---- verification/cec_analog.sv ----
// behavioural analog front end that faces the comparator control block
`timescale 1ns/10ps
module cec_analog (
  input wire logic clock, // system clock
  input wire logic [4:0] plus_high, // plus pin above the minus pins
  output logic [4:0] pos_gt_ref, // plus pin above reference
  output logic [19:0] pos_pin_gt_neg, // plus pin above each minus pin
  output logic [19:0] ref_gt_neg, // reference above each minus pin
  output logic [19:0] neg_present, // minus pins fitted
  output logic [4:0] pos_present // plus pins fitted
);
  // minus pin three sits across plus, so the channel field shows; reference mirrors plus
  always_ff @(posedge clock)
  begin
    for (int c = 0; c < 5; c++)
    begin
      pos_pin_gt_neg[c*4 +: 4] <= {4{plus_high[c]}} ^ 4'h4;
      ref_gt_neg[c*4 +: 4] <= {4{~plus_high[c]}} ^ 4'h4;
    end
    pos_gt_ref <= plus_high;
  end
  // channel two has no fourth minus pin on this package
  assign neg_present = 20'hFFF7F;
  assign pos_present = 5'h1F;
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the comparator event control block
`timescale 1ns/10ps
module testbench;
  import cec_pkg::*;
  logic clock = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, idle_mode = 0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [1:0] wb_sel_i = 2'h0;
  logic [15:0] wb_dat_i = 16'h0000, wb_dat_o, q;
  logic wb_ack_o, combined_irq;
  logic [4:0] plus_high = 5'h00, pos_gt_ref, pos_present, opamp_on, comparator_active;
  logic [4:0] comparator_output_pin, comparator_output_pin_oe;
  logic [19:0] pos_pin_gt_neg, ref_gt_neg, neg_present;
  int num_errors = 0, samples_checked = 0;
  // 100 ns clock
  always #50 clock = ~clock;
  cec_analog cec_analog_i (.clock, .plus_high, .pos_gt_ref, .pos_pin_gt_neg, .ref_gt_neg, .neg_present, .pos_present);
  cec_top cec_top_i (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .idle_mode, .pos_gt_ref, .pos_pin_gt_neg, .ref_gt_neg, .neg_present, .pos_present,
    .comparator_output_pin, .comparator_output_pin_oe, .opamp_on, .comparator_active, .combined_irq);
  // verdict and end of run
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one classic cycle, held until ack, data taken at ack
  task automatic wb(input logic we, input logic [3:0] a, input logic [15:0] d, output logic [15:0] r);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 2'h3;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      num_errors++;
      end_sim();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // register write, and masked read with compare
  task automatic wt(input logic [3:0] a, input logic [15:0] d);
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    wb(1'b0, a, 16'h0000, q);
    chk(q & m, e);
  endtask
  // let the input pipeline settle, stop between edges
  task automatic settle;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  // reset values and an unmapped index
  task automatic t_reset;
    rd(4'h0, 16'hFFFF, 16'h0000);
    rd(4'h1, 16'hFFFF, 16'h0000);
    rd(4'h4, 16'hFFFF, 16'h0000);
    wt(4'h7, 16'hFFFF);
    rd(4'h7, 16'hFFFF, 16'h0000);
  endtask
  // enable, pin drive, polarity and input routing
  task automatic t_route;
    plus_high <= 5'h01;
    wt(4'h1, 16'hC000);
    settle;
    chk({14'h0, comparator_output_pin[0], comparator_output_pin_oe[0]}, 16'h0003);
    rd(4'h1, 16'hFFFF, 16'hC100);
    rd(4'h0, 16'h001F, 16'h0001);
    wt(4'h1, 16'hE000);
    settle;
    rd(4'h1, 16'h0100, 16'h0000);
    wt(4'h1, 16'hC002);
    settle;
    rd(4'h1, 16'h0100, 16'h0000);
    wt(4'h1, 16'hC012);
    settle;
    rd(4'h1, 16'h0100, 16'h0100);
    wt(4'h2, 16'h8003);
    settle;
    rd(4'h2, 16'hFFFF, 16'h8103);
    chk({15'h0, comparator_output_pin_oe[1]}, 16'h0000);
  endtask
  // one edge on comparator one under a given edge code and polarity
  task automatic edge_step(input logic inv, input logic [1:0] code, input logic lvl);
    logic adj, fire;
    adj = lvl ^ inv;
    fire = code == EDGE_ANY || (adj ? code == EDGE_RISE : code == EDGE_FALL);
    plus_high[0] <= ~lvl;
    settle;
    // a polarity switch can fire an event, so clear the flags once it has settled
    wt(4'h1, {2'h3, inv, 5'h00, code, 6'h00});
    settle;
    wt(4'h1, {2'h3, inv, 5'h00, code, 6'h00});
    wt(4'h6, 16'h0000);
    plus_high[0] <= lvl;
    settle;
    rd(4'h1, 16'h0200, {6'h0, fire, 9'h0});
    rd(4'h0, 16'h0101, {7'h0, fire, 7'h0, adj});
    rd(4'h6, 16'h0001, {15'h0, fire});
  endtask
  // a set flag blocks further events; then the combined request
  task automatic t_block;
    wt(4'h6, 16'h0000);
    plus_high[0] <= 1'b0;
    settle;
    rd(4'h6, 16'h0001, 16'h0000);
    rd(4'h1, 16'h0200, 16'h0200);
    wt(4'h1, 16'hC0C0);
    settle;
    wt(4'h1, 16'hC0C0);
    wt(4'h6, 16'h0002);
    plus_high[0] <= 1'b1;
    settle;
    // the combined request is registered one cycle behind the flag
    @(negedge clock);
    chk({15'h0, combined_irq}, 16'h0001);
    rd(4'h6, 16'h0003, 16'h0003);
  endtask
  // stop in idle, then run on in idle
  task automatic t_idle;
    wt(4'h1, 16'hC000);
    wt(4'h0, 16'h8000);
    idle_mode <= 1'b1;
    settle;
    chk({15'h0, comparator_active[0]}, 16'h0000);
    rd(4'h0, 16'h8001, 16'h8000);
    wt(4'h0, 16'h0000);
    settle;
    chk({15'h0, comparator_active[0]}, 16'h0001);
    rd(4'h0, 16'h8001, 16'h0001);
    idle_mode <= 1'b0;
  endtask
  // op amp beside a working comparator; comparator four has none
  task automatic t_opamp;
    wt(4'h1, 16'hC400);
    settle;
    chk({14'h0, opamp_on[0], comparator_active[0]}, 16'h0003);
    rd(4'h0, 16'h0001, 16'h0001);
    wt(4'h4, 16'h9C00);
    settle;
    rd(4'h4, 16'hFFFF, 16'h8000);
    chk({15'h0, opamp_on[3]}, 16'h0000);
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_route();
    for (int i = 0; i < 16; i++)
      edge_step(i[3], i[1:0], i[2]);
    t_block();
    t_idle();
    t_opamp();
    end_sim();
  end
endmodule
